// file: core/rmc_ref_monitor_cfg.sv
// Top of the profile A reference monitor configuration bank: serial
// configuration port, register bank and the settings fed to the monitors.
// Assumes serial clock well below an eighth of clk_sys.
//
// Functional notes
// - Third input mode: 0 auto, 1 profile A, 2 profile B; 3 is refused.
// - Page select register; page 00 general registers, 01 free-run offsets.
// - Profile A multiplier is 14 bits in 8 kHz units, split low/high.
// - Eight-bit single-cycle monitor lower limit for profile A.
// - Eight-bit single-cycle monitor upper limit for profile A.
// - Sixteen-bit coarse monitor lower limit, low byte at lower address.
// - Sixteen-bit coarse monitor upper limit, low byte at lower address.
// - Cycle count programmed minus one; monitor uses stored value plus one.
// - Prescale bit set divides reference by four, lengthening the window.
`default_nettype none

module rmc_ref_monitor_cfg (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n,
   output logic [rmc_pkg::REG_W-1:0] page_select,
   output logic extended_page_active,
   output rmc_pkg::rmc_freq_mode_t third_input_freq_mode,
   output logic third_input_profile_a,
   output logic [rmc_pkg::MULT_W-1:0] profile_a_multiplier,
   output logic [rmc_pkg::KHZ_W-1:0] profile_a_nominal_khz,
   output logic [rmc_pkg::REG_W-1:0] profile_a_single_cycle_lower_limit,
   output logic [rmc_pkg::REG_W-1:0] profile_a_single_cycle_upper_limit,
   output logic [2*rmc_pkg::REG_W-1:0] profile_a_coarse_lower_limit,
   output logic [2*rmc_pkg::REG_W-1:0] profile_a_coarse_upper_limit,
   output logic [rmc_pkg::CYCLES_W-1:0] profile_a_coarse_cycles,
   output logic profile_a_prescale_enable,
   output logic [rmc_pkg::WINDOW_W-1:0] profile_a_window_cycles
);
   import rmc_pkg::*;

   // Pin synchronisers: three stages, a change counts once 2 and 3 agree
   logic [2:0] pin_raw;
   logic [2:0] s1_q, s2_q, s3_q, pin_q;
   logic [2:0] agree;
   logic sclk_f, cs_active, mosi_f;
   logic sclk_prev_q;
   logic rise, fall;

   assign pin_raw = {spi_sclk, spi_cs_n, spi_mosi};
   assign agree = ~(s2_q ^ s3_q);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s1_q <= PIN_IDLE;
         s2_q <= PIN_IDLE;
         s3_q <= PIN_IDLE;
         pin_q <= PIN_IDLE;
         sclk_prev_q <= 1'b0;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= (pin_q & ~agree) | (s3_q & agree);
         sclk_prev_q <= pin_q[2];
      end
   end

   assign sclk_f = pin_q[2];
   assign cs_active = ~pin_q[1];
   assign mosi_f = pin_q[0];
   assign rise = sclk_f & ~sclk_prev_q;
   assign fall = ~sclk_f & sclk_prev_q;

   // Serial engine: address byte (bit 7 = read), then data bytes in bursts
   rmc_spi_state_t state_q, state_d;
   logic [2:0] bit_q, bit_d;
   logic [6:0] rx_q, rx_d;
   logic [REG_W-1:0] rx_byte;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic rd_mode_q, rd_mode_d;
   logic wr_q, wr_d;
   logic [REG_W-1:0] wdata_q, wdata_d;
   logic rd_pend_q, rd_pend_d;
   logic [REG_W-1:0] tx_q, tx_d;
   logic miso_q, miso_d;
   logic oe_n_q, oe_n_d;
   logic byte_done;

   rmc_reg_if rif();

   assign rx_byte = {rx_q, mosi_f};
   assign byte_done = rise && (bit_q == SPI_LAST_BIT);

   always_comb begin
      state_d = state_q;
      bit_d = bit_q;
      rx_d = rx_q;
      addr_d = addr_q;
      rd_mode_d = rd_mode_q;
      wr_d = 1'b0;
      wdata_d = wdata_q;
      rd_pend_d = 1'b0;
      tx_d = tx_q;
      miso_d = miso_q;
      oe_n_d = oe_n_q;
      if (!cs_active) begin
         state_d = RMC_SPI_IDLE;
         bit_d = 3'h0;
         oe_n_d = 1'b1;
      end else begin
         if (rise) begin
            rx_d = rx_byte[6:0];
            bit_d = bit_q + 3'h1;
         end
         case (state_q)
            RMC_SPI_IDLE: begin
               state_d = RMC_SPI_ADDR;
               bit_d = 3'h0;
            end
            RMC_SPI_ADDR: begin
               if (byte_done) begin
                  addr_d = rx_byte[ADDR_W-1:0];
                  rd_mode_d = rx_byte[SPI_RD_BIT];
                  rd_pend_d = rx_byte[SPI_RD_BIT];
                  state_d = RMC_SPI_DATA;
               end
            end
            RMC_SPI_DATA: begin
               if (byte_done && rd_mode_q) begin
                  addr_d = addr_q + 7'h01;
                  rd_pend_d = 1'b1;
               end else if (byte_done) begin
                  wr_d = 1'b1;
                  wdata_d = rx_byte;
               end
               if (fall && rd_mode_q) begin
                  miso_d = tx_q[REG_W-1];
                  tx_d = {tx_q[REG_W-2:0], 1'b0};
                  oe_n_d = 1'b0;
               end
            end
            default: begin
               state_d = RMC_SPI_IDLE;
            end
         endcase
         // Address steps after the write has used it
         if (wr_q) begin
            addr_d = addr_q + 7'h01;
         end
         if (rd_pend_q) begin
            tx_d = rif.rdata;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q <= RMC_SPI_IDLE;
         bit_q <= 3'h0;
         rx_q <= 7'h00;
         addr_q <= 7'h00;
         rd_mode_q <= 1'b0;
         wr_q <= 1'b0;
         wdata_q <= REG_RESET;
         rd_pend_q <= 1'b0;
         tx_q <= REG_RESET;
         miso_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         state_q <= state_d;
         bit_q <= bit_d;
         rx_q <= rx_d;
         addr_q <= addr_d;
         rd_mode_q <= rd_mode_d;
         wr_q <= wr_d;
         wdata_q <= wdata_d;
         rd_pend_q <= rd_pend_d;
         tx_q <= tx_d;
         miso_q <= miso_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign spi_miso = miso_q;
   assign spi_miso_oe_n = oe_n_q;
   assign rif.wr_en = wr_q;
   assign rif.addr = addr_q;
   assign rif.wdata = wdata_q;

   rmc_reg_bank u_bank (
      .clk_sys(clk_sys),
      .reset(reset),
      .rif(rif)
   );

   // Settings handed to the monitors, one cycle behind the bank
   logic [NUM_SLOTS-1:0][REG_W-1:0] img;
   logic [MULT_W-1:0] mult_c;
   logic [CYCLES_W-1:0] cycles_c;
   logic presc_c;
   rmc_freq_mode_t mode_c;

   assign img = rif.image;
   assign mult_c = {img[IDX_MULT_HI][MULT_HI_W-1:0], img[IDX_MULT_LO]};
   assign cycles_c = {1'b0, img[IDX_CYCLE]} + CYCLES_RESET;
   assign presc_c = img[IDX_PRESC][PRESC_BIT];
   assign mode_c = rmc_freq_mode_t'(img[IDX_MODE][MODE_MSB:MODE_LSB]);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         page_select <= PAGE_GENERAL;
         extended_page_active <= 1'b0;
         third_input_freq_mode <= RMC_FREQ_AUTO;
         third_input_profile_a <= 1'b0;
         profile_a_multiplier <= '0;
         profile_a_nominal_khz <= '0;
         profile_a_single_cycle_lower_limit <= REG_RESET;
         profile_a_single_cycle_upper_limit <= REG_RESET;
         profile_a_coarse_lower_limit <= '0;
         profile_a_coarse_upper_limit <= '0;
         profile_a_coarse_cycles <= CYCLES_RESET;
         profile_a_prescale_enable <= 1'b0;
         profile_a_window_cycles <= WINDOW_RESET;
      end else begin
         page_select <= img[IDX_PAGE];
         extended_page_active <= img[IDX_PAGE] == PAGE_FREERUN;
         third_input_freq_mode <= mode_c;
         third_input_profile_a <= mode_c == RMC_FREQ_PROFILE_A;
         profile_a_multiplier <= mult_c;
         profile_a_nominal_khz <= {mult_c, 3'h0};
         profile_a_single_cycle_lower_limit <= img[IDX_SCM_LO];
         profile_a_single_cycle_upper_limit <= img[IDX_SCM_HI];
         profile_a_coarse_lower_limit <= {img[IDX_CFM_LO_H], img[IDX_CFM_LO_L]};
         profile_a_coarse_upper_limit <= {img[IDX_CFM_HI_H], img[IDX_CFM_HI_L]};
         profile_a_coarse_cycles <= cycles_c;
         profile_a_prescale_enable <= presc_c;
         // Divided reference needs four times the clock cycles per window
         profile_a_window_cycles <= presc_c ?
            {cycles_c, 2'h0} : {2'h0, cycles_c};
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   sequence s_wr_at(logic [ADDR_W-1:0] ofs);
      rif.wr_en && rif.hit && (rif.addr == ofs);
   endsequence

   sequence s_mode_wr3;
      s_wr_at(OFS_MODE) ##0 (rif.wdata[MODE_MSB:MODE_LSB] == RMC_FREQ_RESERVED);
   endsequence

   mode_code_refused_a: assert property (
      s_mode_wr3 |=> ##1 (third_input_freq_mode == $past(third_input_freq_mode, 2)))
      else $error("reserved mode code was accepted");

   mode_never_reserved_a: assert property (
      third_input_freq_mode != RMC_FREQ_RESERVED)
      else $error("third input mode shows reserved code");

   page_gate_a: assert property (
      (rif.wr_en && (img[IDX_PAGE] != PAGE_GENERAL) && (rif.addr != OFS_PAGE))
      |=> $stable(img))
      else $error("write reached a hidden page register");

   mult_join_a: assert property (
      (profile_a_multiplier == $past(mult_c)) &&
      (profile_a_nominal_khz == {profile_a_multiplier, 3'h0}))
      else $error("multiplier or nominal frequency wrong");

   scm_lower_a: assert property (
      s_wr_at(OFS_SCM_LO) |=> ##1
      (profile_a_single_cycle_lower_limit == $past(rif.wdata, 2)))
      else $error("single-cycle lower limit not taken");

   scm_upper_a: assert property (
      s_wr_at(OFS_SCM_HI) |=> ##1
      (profile_a_single_cycle_upper_limit == $past(rif.wdata, 2)))
      else $error("single-cycle upper limit not taken");

   cfm_lower_a: assert property (
      s_wr_at(OFS_CFM_LO_H) |=> ##1
      (profile_a_coarse_lower_limit[2*REG_W-1:REG_W] == $past(rif.wdata, 2)))
      else $error("coarse lower limit high byte misplaced");

   cfm_upper_a: assert property (
      s_wr_at(OFS_CFM_HI_L) |=> ##1
      (profile_a_coarse_upper_limit[REG_W-1:0] == $past(rif.wdata, 2)))
      else $error("coarse upper limit low byte misplaced");

   cycle_plus_one_a: assert property (
      profile_a_coarse_cycles == ($past({1'b0, img[IDX_CYCLE]}) + CYCLES_RESET))
      else $error("cycle count is not stored value plus one");

   window_scale_a: assert property (
      profile_a_window_cycles == (profile_a_prescale_enable ?
         {profile_a_coarse_cycles, 2'h0} : {2'h0, profile_a_coarse_cycles}))
      else $error("window length ignores prescale");

   profile_follow_a: assert property (
      third_input_profile_a == (third_input_freq_mode == RMC_FREQ_PROFILE_A))
      else $error("profile A select disagrees with mode");

   miso_release_a: assert property (
      !cs_active |=> spi_miso_oe_n)
      else $error("data out driven with select inactive");

endmodule

`default_nettype wire

// file: shared/rmc_pkg.sv
// Constants, field layouts and types for the profile A reference monitor
// configuration bank. Assumes byte-wide registers behind a serial port.
`default_nettype none

package rmc_pkg;

   localparam int REG_W = 8;
   localparam int ADDR_W = 7;
   localparam int NUM_SLOTS = 13;

   // Register offsets on the serial port
   localparam logic [ADDR_W-1:0] OFS_PAGE = 7'h64;
   localparam logic [ADDR_W-1:0] OFS_MODE = 7'h65;
   localparam logic [ADDR_W-1:0] OFS_MULT_LO = 7'h67;
   localparam logic [ADDR_W-1:0] OFS_MULT_HI = 7'h68;
   localparam logic [ADDR_W-1:0] OFS_SCM_LO = 7'h69;
   localparam logic [ADDR_W-1:0] OFS_SCM_HI = 7'h6a;
   localparam logic [ADDR_W-1:0] OFS_CFM_LO_L = 7'h6b;
   localparam logic [ADDR_W-1:0] OFS_CFM_LO_H = 7'h6c;
   localparam logic [ADDR_W-1:0] OFS_CFM_HI_L = 7'h6d;
   localparam logic [ADDR_W-1:0] OFS_CFM_HI_H = 7'h6e;
   localparam logic [ADDR_W-1:0] OFS_CYCLE = 7'h6f;
   localparam logic [ADDR_W-1:0] OFS_PRESC = 7'h70;

   // Slot index is offset minus the page register offset
   localparam logic [3:0] IDX_PAGE = 4'h0;
   localparam logic [3:0] IDX_MODE = 4'h1;
   localparam logic [3:0] IDX_MULT_LO = 4'h3;
   localparam logic [3:0] IDX_MULT_HI = 4'h4;
   localparam logic [3:0] IDX_SCM_LO = 4'h5;
   localparam logic [3:0] IDX_SCM_HI = 4'h6;
   localparam logic [3:0] IDX_CFM_LO_L = 4'h7;
   localparam logic [3:0] IDX_CFM_LO_H = 4'h8;
   localparam logic [3:0] IDX_CFM_HI_L = 4'h9;
   localparam logic [3:0] IDX_CFM_HI_H = 4'ha;
   localparam logic [3:0] IDX_CYCLE = 4'hb;
   localparam logic [3:0] IDX_PRESC = 4'hc;

   // Writable bits per slot, slot 12 leftmost; slot 2 is a hole
   localparam logic [NUM_SLOTS-1:0][REG_W-1:0] WR_MASK = {
      8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'h3f, 8'hff, 8'h00, 8'h3f, 8'hff};
   localparam logic [REG_W-1:0] REG_RESET = 8'h00;

   // Field positions
   localparam int MODE_LSB = 4;
   localparam int MODE_MSB = 5;
   localparam int MULT_HI_W = 6;
   localparam int MULT_W = 14;
   localparam int PRESC_BIT = 0;
   localparam int PRESC_SHIFT = 2;
   localparam int FREQ_UNIT_SHIFT = 3;
   localparam int CYCLES_W = 9;
   localparam int WINDOW_W = CYCLES_W + PRESC_SHIFT;
   localparam int KHZ_W = MULT_W + FREQ_UNIT_SHIFT;
   localparam logic [CYCLES_W-1:0] CYCLES_RESET = 9'h001;
   localparam logic [WINDOW_W-1:0] WINDOW_RESET = 11'h001;

   localparam logic [REG_W-1:0] PAGE_GENERAL = 8'h00;
   localparam logic [REG_W-1:0] PAGE_FREERUN = 8'h01;

   typedef enum logic [1:0] {
      RMC_FREQ_AUTO = 2'h0,
      RMC_FREQ_PROFILE_A = 2'h1,
      RMC_FREQ_PROFILE_B = 2'h2,
      RMC_FREQ_RESERVED = 2'h3
   } rmc_freq_mode_t;

   // Serial port framing
   localparam int SPI_RD_BIT = 7;
   localparam logic [2:0] SPI_LAST_BIT = 3'h7;
   localparam logic [2:0] PIN_IDLE = 3'h2;

   typedef enum logic [1:0] {
      RMC_SPI_IDLE = 2'b00,
      RMC_SPI_ADDR = 2'b01,
      RMC_SPI_DATA = 2'b11
   } rmc_spi_state_t;

endpackage

`default_nettype wire

// file: shared/rmc_reg_if.sv
// Carrier between the serial port engine and the register bank.
// Assumes one clock; the bank answers reads combinationally.
`default_nettype none

interface rmc_reg_if;
   import rmc_pkg::*;
   logic wr_en;
   logic [ADDR_W-1:0] addr;
   logic [REG_W-1:0] wdata;
   logic [REG_W-1:0] rdata;
   logic hit;
   logic [NUM_SLOTS-1:0][REG_W-1:0] image;

   modport port (output wr_en, output addr, output wdata,
                 input rdata, input hit, input image);
   modport bank (input wr_en, input addr, input wdata,
                 output rdata, output hit, output image);
endinterface

`default_nettype wire

// file: core/rmc_reg_bank.sv
// Register storage for the profile A configuration and page select.
// Assumes single-cycle write strobes from the serial port engine.
`default_nettype none

module rmc_reg_bank (
   input wire logic clk_sys,
   input wire logic reset,
   rmc_reg_if.bank rif
);
   import rmc_pkg::*;

   logic [NUM_SLOTS-1:0][REG_W-1:0] regs_q;
   logic [ADDR_W-1:0] rel;
   logic in_range;
   logic [3:0] idx;
   logic mapped;
   logic page_open;
   logic mode_bad;
   logic [REG_W-1:0] merged;
   logic [REG_W-1:0] wr_val;

   assign rel = rif.addr - OFS_PAGE;
   assign in_range = (rif.addr >= OFS_PAGE) && (rif.addr <= OFS_PRESC);
   assign idx = in_range ? rel[3:0] : IDX_PAGE;
   assign mapped = in_range && (WR_MASK[idx] != REG_RESET);
   // Other pages hide everything but the page register itself
   assign page_open = (regs_q[IDX_PAGE] == PAGE_GENERAL) || (rif.addr == OFS_PAGE);
   assign rif.hit = mapped && page_open;
   assign rif.rdata = rif.hit ? regs_q[idx] : REG_RESET;
   assign rif.image = regs_q;

   // A reserved mode code is refused; the field keeps its old value
   assign mode_bad = (idx == IDX_MODE) &&
                     (rif.wdata[MODE_MSB:MODE_LSB] == RMC_FREQ_RESERVED);
   assign merged = {rif.wdata[REG_W-1:MODE_MSB+1], regs_q[IDX_MODE][MODE_MSB:MODE_LSB],
                    rif.wdata[MODE_LSB-1:0]};
   assign wr_val = (mode_bad ? merged : rif.wdata) & WR_MASK[idx];

   for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
      always_ff @(posedge clk_sys or posedge reset) begin
         if (reset) begin
            regs_q[g] <= REG_RESET;
         end else if (rif.wr_en && rif.hit && (idx == 4'(g))) begin
            regs_q[g] <= wr_val;
         end
      end
   end

endmodule

`default_nettype wire

// file: dv/rmc_ref_monitor_cfg_tb.sv
// Self-checking bench for the profile A monitor configuration bank.
// Assumes the design package, interface and modules are compiled first.
`default_nettype none

module rmc_ref_monitor_cfg_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rmc_pkg::*;

   logic clk_sys, reset, spi_sclk, spi_cs_n, spi_mosi;
   logic spi_miso, spi_miso_oe_n, extended_page_active, third_input_profile_a;
   logic [REG_W-1:0] page_select;
   rmc_freq_mode_t third_input_freq_mode;
   logic [MULT_W-1:0] profile_a_multiplier;
   logic [KHZ_W-1:0] profile_a_nominal_khz;
   logic [7:0] profile_a_single_cycle_lower_limit, profile_a_single_cycle_upper_limit;
   logic [15:0] profile_a_coarse_lower_limit, profile_a_coarse_upper_limit;
   logic [CYCLES_W-1:0] profile_a_coarse_cycles;
   logic profile_a_prescale_enable;
   logic [WINDOW_W-1:0] profile_a_window_cycles;
   int n_mismatch, checks_done, cycle_cnt;
   // Expected register image, slot = offset minus page offset
   logic [7:0] mdl [13];

   rmc_ref_monitor_cfg rmc_ref_monitor_cfg_i (
      .clk_sys(clk_sys), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
      .page_select(page_select), .extended_page_active(extended_page_active),
      .third_input_freq_mode(third_input_freq_mode),
      .third_input_profile_a(third_input_profile_a),
      .profile_a_multiplier(profile_a_multiplier),
      .profile_a_nominal_khz(profile_a_nominal_khz),
      .profile_a_single_cycle_lower_limit(profile_a_single_cycle_lower_limit),
      .profile_a_single_cycle_upper_limit(profile_a_single_cycle_upper_limit),
      .profile_a_coarse_lower_limit(profile_a_coarse_lower_limit),
      .profile_a_coarse_upper_limit(profile_a_coarse_upper_limit),
      .profile_a_coarse_cycles(profile_a_coarse_cycles),
      .profile_a_prescale_enable(profile_a_prescale_enable),
      .profile_a_window_cycles(profile_a_window_cycles));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk_out(input logic [16:0] got, input logic [16:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_reg(input logic [6:0] a, input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: read %h got %h expected %h", $time, a, got, exp);
      end
   endtask

   // Sclk levels held 8 clocks, twice the minimum, so miso has settled when sampled
   task automatic spi_bit(input logic b, output logic r, output logic oe);
      spi_mosi <= b;
      spi_sclk <= 1'b0;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      r = spi_miso;
      oe = spi_miso_oe_n;
      @(posedge clk_sys) spi_sclk <= 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask

   task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx, output logic [7:0] oe);
      for (int i = 7; i >= 0; i--) spi_bit(tx[i], rx[i], oe[i]);
   endtask

   task automatic frame_begin();
      spi_cs_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask

   task automatic frame_end();
      spi_sclk <= 1'b0;
      repeat (8) @(posedge clk_sys);
      spi_cs_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask

   task automatic model_write(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] old;
      old = mdl[1];
      if (a == OFS_PAGE) mdl[0] = d;
      else if (mdl[0] == 8'h00 && a >= OFS_MODE && a <= OFS_PRESC && a != 7'h66) begin
         case (a)
            OFS_MODE: mdl[1] = {2'h0, (d[5:4] == 2'h3) ? old[5:4] : d[5:4], d[3:0]};
            OFS_MULT_HI: mdl[4] = d & 8'h3f;
            OFS_PRESC: mdl[12] = d & 8'h01;
            default: mdl[a - OFS_PAGE] = d;
         endcase
      end
   endtask

   // Burst write; address auto-increments after each data byte
   task automatic reg_burst(input logic [6:0] a, input logic [7:0] d [11], input int n);
      logic [7:0] r, oe;
      frame_begin();
      spi_byte({1'b0, a}, r, oe);
      for (int i = 0; i < n; i++) begin
         spi_byte(d[i], r, oe);
         model_write(a + 7'(i), d[i]);
      end
      frame_end();
   endtask

   task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q [11];
      q[0] = d;
      reg_burst(a, q, 1);
   endtask

   task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
      logic [7:0] oe;
      frame_begin();
      spi_byte({1'b1, a}, d, oe);
      chk_out(17'(oe), 17'h000ff, "oe_n during address");
      spi_byte(8'h00, d, oe);
      chk_out(17'(oe), 17'h00000, "oe_n during data");
      frame_end();
      chk_out(17'(spi_miso_oe_n), 17'h1, "oe_n after frame");
   endtask

   task automatic chk_regs();
      logic [7:0] d, e;
      logic [6:0] a;
      for (int i = 0; i < 13; i++) begin
         a = OFS_PAGE + 7'(i);
         e = (i == 2 || (mdl[0] != 8'h00 && i != 0)) ? 8'h00 : mdl[i];
         reg_read(a, d);
         chk_reg(a, d, e);
      end
   endtask

   task automatic chk_outputs();
      logic [13:0] m;
      logic [8:0] c;
      m = {mdl[4][5:0], mdl[3]};
      c = 9'(mdl[11]) + 9'h001;
      chk_out(17'(page_select), 17'(mdl[0]), "page");
      chk_out(17'(extended_page_active), 17'(mdl[0] == 8'h01), "ext page");
      chk_out(17'(third_input_freq_mode), 17'(mdl[1][5:4]), "mode");
      chk_out(17'(third_input_profile_a), 17'(mdl[1][5:4] == 2'h1), "prof a");
      chk_out(17'(profile_a_multiplier), 17'(m), "mult");
      chk_out(17'(profile_a_nominal_khz), {m, 3'h0}, "khz");
      chk_out(17'(profile_a_single_cycle_lower_limit), 17'(mdl[5]), "scm lo");
      chk_out(17'(profile_a_single_cycle_upper_limit), 17'(mdl[6]), "scm hi");
      chk_out(17'(profile_a_coarse_lower_limit), 17'({mdl[8], mdl[7]}), "cfm lo");
      chk_out(17'(profile_a_coarse_upper_limit), 17'({mdl[10], mdl[9]}), "cfm hi");
      chk_out(17'(profile_a_coarse_cycles), 17'(c), "cycles");
      chk_out(17'(profile_a_prescale_enable), 17'(mdl[12][0]), "presc");
      chk_out(17'(profile_a_window_cycles), mdl[12][0] ? 17'({c, 2'h0}) : 17'(c), "win");
   endtask

   task automatic t_reset();
      logic [7:0] d;
      chk_outputs();
      chk_regs();
      reg_read(7'h71, d);
      chk_reg(7'h71, d, 8'h00);
      $display("test reset done");
   endtask

   // Burst from the hole at 0x66 across all profile A registers
   task automatic t_values();
      logic [7:0] d, oe;
      // Reference of 0x3fa5 times 8 kHz is well above 19.44 MHz, so prescale goes on
      reg_burst(7'h66, '{8'hff, 8'ha5, 8'hff, 8'h12, 8'h34, 8'h78, 8'h56,
                         8'hbc, 8'h9a, 8'hff, 8'hff}, 11);
      chk_outputs();
      chk_regs();
      // Read burst must step the address after each data byte
      frame_begin();
      spi_byte({1'b1, OFS_CFM_LO_L}, d, oe);
      spi_byte(8'h00, d, oe);
      chk_reg(OFS_CFM_LO_L, d, mdl[7]);
      spi_byte(8'h00, d, oe);
      chk_reg(OFS_CFM_LO_H, d, mdl[8]);
      frame_end();
      $display("test values done");
   endtask

   task automatic t_prescale();
      logic [7:0] p [3] = '{8'h00, 8'h01, 8'hfe};
      reg_write(OFS_CYCLE, 8'h00);
      foreach (p[i]) begin
         reg_write(OFS_PRESC, p[i]);
         chk_outputs();
      end
      $display("test prescale done");
   endtask

   // Code 3 comes last so the refused write must keep profile B
   task automatic t_mode();
      logic [1:0] codes [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
      logic [7:0] d;
      foreach (codes[i]) begin
         reg_write(OFS_MODE, {2'h3, codes[i], 2'(i), ~codes[i]});
         chk_outputs();
         reg_read(OFS_MODE, d);
         chk_reg(OFS_MODE, d, mdl[1]);
      end
      $display("test mode done");
   endtask

   task automatic t_page();
      reg_write(OFS_PAGE, PAGE_FREERUN);
      reg_write(OFS_SCM_LO, 8'hee);
      chk_outputs();
      chk_regs();
      reg_write(OFS_PAGE, 8'h0f);
      chk_outputs();
      reg_write(OFS_PAGE, PAGE_GENERAL);
      chk_regs();
      $display("test page done");
   endtask

   // Chip select lifted mid-byte must leave the limit untouched
   task automatic t_abort();
      logic [7:0] r, oe;
      frame_begin();
      spi_byte({1'b0, OFS_SCM_HI}, r, oe);
      for (int i = 0; i < 4; i++) spi_bit(1'b1, r[i], oe[i]);
      frame_end();
      chk_outputs();
      reg_write(OFS_SCM_HI, 8'h5a);
      chk_outputs();
      $display("test abort done");
   endtask

   initial begin
      reset = 1'b1;
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      foreach (mdl[i]) mdl[i] = 8'h00;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (4) @(posedge clk_sys);
      t_reset();
      t_values();
      t_prescale();
      t_mode();
      t_page();
      t_abort();
      print_verdict();
   end

   // Whole run needs about 23000 cycles
   initial begin
      cycle_cnt = 0;
      forever begin
         @(posedge clk_sys);
         cycle_cnt++;
         if (cycle_cnt == 90000) begin
            n_mismatch++;
            $display("mismatch at %0t: run timed out", $time);
            print_verdict();
         end
      end
   end
endmodule

`default_nettype wire
